/* File: core/timer_aux.sv */
// Purpose: Two reloadable timers with trigger start, pin control, PWM gating and watchdog
// Assumes: Prescaler and oscillator ticks are one-cycle pulses on clk
// Notes: Registers are written by instruction through the accumulator; only control registers a and b are read back
`timescale 1ns/1ps
`include "timer_aux_regs.svh"
module timer_aux #(
    parameter int W = 8,
    parameter int WDT_LIMIT = `WDT_LIMIT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire timer_aux_pkg::instr_type instr,
    input wire logic [W-1:0] instr_data,
    output logic [3:0] acc_out_r,
    input wire logic prescaler_out,
    input wire logic osc_tick,
    input wire logic machine_cycle,
    input wire logic trigger_pin,
    input wire logic counter_pin_zero_in,
    output logic counter_pin_zero_out_r,
    output logic counter_pin_zero_oe_r,
    input wire logic counter_pin_one_in,
    output logic counter_pin_one_out_r,
    output logic counter_pin_one_oe_r,
    input wire logic shared_port_bit_a_out,
    input wire logic shared_port_bit_a_oe,
    input wire logic shared_port_bit_b_out,
    input wire logic shared_port_bit_b_oe,
    output logic timer1_irq_r,
    output logic timer2_irq_r,
    output logic [W-1:0] period_r,
    output logic period_valid_r,
    output logic wdt_reset_r
);
    import timer_aux_pkg::*;

    // ****************************************
    // Parameter checks
    // ****************************************
    if (W < 2 || W > 16) begin : g_bad_width
        $error("timer width must be 2 to 16");
    end
    if (WDT_LIMIT < 2 || WDT_LIMIT > 65535) begin : g_bad_wdt
        $error("watchdog limit must fit 16 bits");
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic [3:0] timer1_trigger_and_pin0_ctrl;
    logic [3:0] pin1_output_and_period_ctrl;
    logic [3:0] timer1_ctrl_reg;
    logic [3:0] timer2_ctrl_reg;
    logic [3:0] trigger_pin_ctrl_reg;
    logic [W-1:0] t1_reload_r;
    logic [W-1:0] timer2_low_reload;
    logic [W-1:0] timer2_high_reload;
    logic wr;
    assign wr = instr_valid;
    // Register writes from the accumulator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer1_trigger_and_pin0_ctrl <= `CTRL_RST;
            pin1_output_and_period_ctrl <= `CTRL_RST;
            timer1_ctrl_reg <= `CTRL_RST;
            timer2_ctrl_reg <= `CTRL_RST;
            trigger_pin_ctrl_reg <= `CTRL_RST;
        end else if (wr) begin
            unique case (instr)
                ins_write_a: timer1_trigger_and_pin0_ctrl <= instr_data[3:0];
                ins_write_b: pin1_output_and_period_ctrl <= instr_data[3:0];
                ins_write_t1: timer1_ctrl_reg <= instr_data[3:0];
                ins_write_t2: timer2_ctrl_reg <= instr_data[3:0];
                ins_write_trig: trigger_pin_ctrl_reg <= instr_data[3:0];
                default: ;
            endcase
        end
    end
    // Reload values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t1_reload_r <= '0;
            timer2_low_reload <= '0;
            timer2_high_reload <= '0;
        end else if (wr) begin
            if (instr == ins_reload_t1)
                t1_reload_r <= instr_data;
            if (instr == ins_reload_t2l)
                timer2_low_reload <= instr_data;
            if (instr == ins_reload_t2h)
                timer2_high_reload <= instr_data;
        end
    end
    // Read back into the accumulator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_out_r <= `CTRL_RST;
        end else if (wr && instr == ins_read_a) begin
            acc_out_r <= timer1_trigger_and_pin0_ctrl;
        end else if (wr && instr == ins_read_b) begin
            acc_out_r <= pin1_output_and_period_ctrl;
        end
    end

    // ****************************************
    // Pin synchronisers and edge selection
    // ****************************************
    logic [2:0] pin_in;
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    assign pin_in = {trigger_pin, counter_pin_one_in, counter_pin_zero_in};
    for (genvar i = 0; i < 3; i++) begin : g_pin
        pin_edge u_edge (
            .clk(clk),
            .rstn(rstn),
            .pin(pin_in[i]),
            .level(pin_lvl[i]),
            .rise(pin_rise[i]),
            .fall(pin_fall[i])
        );
    end
    // Pick the counted edge of a pin
    function automatic logic pick_edge(input logic sel_rise, input logic r, input logic f);
        pick_edge = sel_rise ? r : f;
    endfunction : pick_edge
    logic cnt0_edge;
    logic cnt1_edge;
    logic trig_edge;
    assign cnt0_edge = pick_edge(timer1_trigger_and_pin0_ctrl[`CA_EDGE0], pin_rise[0], pin_fall[0]);
    assign cnt1_edge = pick_edge(pin1_output_and_period_ctrl[`CB_EDGE1], pin_rise[1], pin_fall[1]);
    // Trigger edge: one-sided by polarity or both edges
    assign trig_edge = trigger_pin_ctrl_reg[`TR_INEN]
        & (trigger_pin_ctrl_reg[`TR_BOTH] ? (pin_rise[2] | pin_fall[2])
        : pick_edge(trigger_pin_ctrl_reg[`TR_POL], pin_rise[2], pin_fall[2]));

    // ****************************************
    // Trigger start and auto-stop of timer 1
    // ****************************************
    trig_state_type trig_r;
    logic trig_ctl;
    logic sync_on;
    logic astop_on;
    logic t1_udf;
    assign trig_ctl = trigger_pin_ctrl_reg[`TR_T1EN];
    assign sync_on = trig_ctl & timer1_trigger_and_pin0_ctrl[`CA_SYNC];
    assign astop_on = sync_on & timer1_trigger_and_pin0_ctrl[`CA_ASTOP];
    // Armed waits for a trigger edge, run counts, auto-stop returns to armed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_r <= trg_idle;
        end else if (!sync_on || !timer1_ctrl_reg[`TC_RUN]) begin
            trig_r <= trg_idle;
        end else begin
            unique case (trig_r)
                trg_idle: trig_r <= trg_armed;
                trg_armed: if (trig_edge) trig_r <= trg_run;
                trg_run: if (astop_on && t1_udf) trig_r <= trg_armed;
                default: trig_r <= trg_idle;
            endcase
        end
    end

    // ****************************************
    // Timer 1
    // ****************************************
    logic [W-1:0] t1_cnt_r;
    logic t1_src;
    logic t1_go;
    logic pwm_r;
    logic pwm_rise;
    logic pwm_last_r;
    assign pwm_rise = pwm_r & ~pwm_last_r;
    // Count source selection
    always_comb begin
        unique case (timer1_ctrl_reg[`TC_SRC_HI:`TC_SRC_LO])
            `SRC_0: t1_src = pwm_rise;
            `SRC_1: t1_src = prescaler_out;
            `SRC_2: t1_src = cnt1_edge;
            `SRC_3: t1_src = osc_tick;
        endcase
    end
    // With sync start the timer only runs after the trigger edge
    assign t1_go = timer1_ctrl_reg[`TC_RUN] & (!sync_on | trig_r == trg_run);
    assign t1_udf = t1_go & t1_src & (t1_cnt_r == '0);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t1_cnt_r <= '0;
        end else if (!timer1_ctrl_reg[`TC_RUN] && wr && instr == ins_reload_t1) begin
            t1_cnt_r <= instr_data;
        end else if (t1_go && t1_src) begin
            t1_cnt_r <= (t1_cnt_r == '0) ? t1_reload_r : t1_cnt_r - 1'b1;
        end else if (trig_r == trg_armed) begin
            t1_cnt_r <= t1_reload_r;
        end
    end
    // Interrupt pulse on underflow
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            timer1_irq_r <= 1'b0;
        else
            timer1_irq_r <= t1_udf;
    end

    // ****************************************
    // Timer 2, PWM and period count
    // ****************************************
    logic [W-1:0] t2_cnt_r;
    logic t2_src;
    logic t2_go;
    logic t2_udf;
    logic per_on;
    logic per_edge;
    assign per_on = pin1_output_and_period_ctrl[`CB_PERIOD];
    assign per_edge = per_on & trigger_pin_ctrl_reg[`TR_INEN] & pin_rise[2];
    always_comb begin
        unique case (timer2_ctrl_reg[`TC_SRC_HI:`TC_SRC_LO])
            `SRC_0: t2_src = t1_udf;
            `SRC_1: t2_src = prescaler_out;
            `SRC_2: t2_src = cnt0_edge;
            `SRC_3: t2_src = 1'b1;
        endcase
    end
    assign t2_go = timer2_ctrl_reg[`TC_RUN];
    assign t2_udf = t2_go & t2_src & (t2_cnt_r == '0);
    // Down count; PWM picks the next reload by the phase being entered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t2_cnt_r <= '0;
        end else if (t2_go && per_edge) begin
            t2_cnt_r <= timer2_low_reload;
        end else if (!t2_go && wr && instr == ins_reload_t2l) begin
            t2_cnt_r <= instr_data;
        end else if (t2_go && t2_src) begin
            if (t2_cnt_r != '0)
                t2_cnt_r <= t2_cnt_r - 1'b1;
            else if (timer2_ctrl_reg[`TC_PWM] && !pwm_r)
                t2_cnt_r <= timer2_high_reload;
            else
                t2_cnt_r <= timer2_low_reload;
        end
    end
    // PWM level toggles at each underflow, low phase first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_r <= 1'b0;
            pwm_last_r <= 1'b0;
        end else begin
            pwm_last_r <= pwm_r;
            if (!timer2_ctrl_reg[`TC_PWM])
                pwm_r <= 1'b0;
            else if (t2_udf)
                pwm_r <= ~pwm_r;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            timer2_irq_r <= 1'b0;
        else
            timer2_irq_r <= t2_udf;
    end
    // Capture the count left at each trigger rising edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            period_r <= '0;
            period_valid_r <= 1'b0;
        end else begin
            period_valid_r <= t2_go & per_edge;
            if (t2_go && per_edge)
                period_r <= t2_cnt_r;
        end
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    logic t1_wave_r;
    logic gate_r;
    logic auto_on;
    assign auto_on = pin1_output_and_period_ctrl[`CB_AUTO];
    // Timer 1 square wave and the PWM pass gate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t1_wave_r <= 1'b0;
            gate_r <= 1'b0;
        end else begin
            if (t1_udf)
                t1_wave_r <= ~t1_wave_r;
            if (!auto_on)
                gate_r <= 1'b0;
            else if (t1_udf)
                gate_r <= ~gate_r;
        end
    end
    // Counter pin 0 is timer output when selected, else port bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_pin_zero_out_r <= 1'b0;
            counter_pin_zero_oe_r <= 1'b0;
        end else if (timer1_trigger_and_pin0_ctrl[`CA_PIN0]) begin
            counter_pin_zero_out_r <= t1_wave_r;
            counter_pin_zero_oe_r <= 1'b1;
        end else begin
            counter_pin_zero_out_r <= shared_port_bit_a_out;
            counter_pin_zero_oe_r <= shared_port_bit_a_oe;
        end
    end
    // Counter pin 1 carries PWM, gated when auto-control is on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_pin_one_out_r <= 1'b0;
            counter_pin_one_oe_r <= 1'b0;
        end else if (pin1_output_and_period_ctrl[`CB_PIN1]) begin
            counter_pin_one_out_r <= pwm_r & (!auto_on | gate_r);
            counter_pin_one_oe_r <= 1'b1;
        end else begin
            counter_pin_one_out_r <= shared_port_bit_b_out;
            counter_pin_one_oe_r <= shared_port_bit_b_oe;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    logic wdt_en_r;
    logic [15:0] wdt_cnt_r;
    logic wdt_kick;
    assign wdt_kick = wr && instr == ins_wdt_restart;
    // First restart arms the watchdog; later ones clear it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdt_en_r <= 1'b0;
            wdt_cnt_r <= 16'h0000;
            wdt_reset_r <= 1'b0;
        end else begin
            wdt_reset_r <= 1'b0;
            if (wdt_kick) begin
                wdt_en_r <= 1'b1;
                wdt_cnt_r <= 16'h0000;
            end else if (wdt_en_r && machine_cycle) begin
                if (wdt_cnt_r >= 16'(WDT_LIMIT - 1)) begin
                    wdt_reset_r <= 1'b1;
                    wdt_en_r <= 1'b0;
                    wdt_cnt_r <= 16'h0000;
                end else begin
                    wdt_cnt_r <= wdt_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    auto_stop_a: assert property (trig_r == trg_run && astop_on && t1_udf && timer1_ctrl_reg[`TC_RUN]
        && !(wr && (instr == ins_write_t1 || instr == ins_write_a || instr == ins_write_trig))
        |=> trig_r == trg_armed) else $error("auto-stop missed");
    sync_hold_a: assert property (sync_on && trig_r != trg_run |-> !t1_udf)
        else $error("timer 1 ran before trigger");
    trig_start_a: assert property (trig_r == trg_armed && trig_edge && sync_on && timer1_ctrl_reg[`TC_RUN]
        && !wr |=> trig_r == trg_run) else $error("trigger did not start timer 1");
    t1_irq_a: assert property (t1_udf |=> timer1_irq_r) else $error("timer 1 interrupt lost");
    t1_wave_a: assert property (timer1_irq_r |-> t1_wave_r != $past(t1_wave_r))
        else $error("wave not toggled with interrupt");
    edge0_sel_a: assert property (timer1_trigger_and_pin0_ctrl[`CA_EDGE0] |-> cnt0_edge == pin_rise[0])
        else $error("pin 0 edge select wrong");
    edge1_sel_a: assert property (!pin1_output_and_period_ctrl[`CB_EDGE1] |-> cnt1_edge == pin_fall[1])
        else $error("pin 1 edge select wrong");
    pwm_reload_a: assert property (t2_udf && timer2_ctrl_reg[`TC_PWM] && !pwm_r && !per_edge
        |=> t2_cnt_r == $past(timer2_high_reload)) else $error("high reload missed");
    gate_toggle_a: assert property (auto_on && t1_udf && $past(auto_on) |=> gate_r != $past(gate_r))
        else $error("gate not toggled");
    pin1_mode_a: assert property (pin1_output_and_period_ctrl[`CB_PIN1] |=> counter_pin_one_oe_r)
        else $error("pin 1 not driven");
    period_cap_a: assert property (t2_go && per_edge |=> period_valid_r && period_r == $past(t2_cnt_r))
        else $error("period not captured");
    wdt_fire_a: assert property (wdt_en_r && machine_cycle && !wdt_kick && wdt_cnt_r == 16'(WDT_LIMIT - 1)
        |=> wdt_reset_r) else $error("watchdog did not fire");
    readback_a: assert property (wr && instr == ins_read_b |=> acc_out_r == $past(pin1_output_and_period_ctrl))
        else $error("read back mismatch");
    start_cov: cover property (trig_r == trg_armed ##1 trig_r == trg_run);
    pwm_cov: cover property (counter_pin_one_oe_r && counter_pin_one_out_r);
    wdt_cov: cover property (wdt_reset_r);
    period_cov: cover property (period_valid_r);
endmodule : timer_aux

/* File: core/timer_aux_regs.svh */
// Purpose: Constants for the dual timer auxiliary control block
// Assumes: Registers are reached through the accumulator by instruction
// Notes: Field positions, reset values and counts used by the logic
`ifndef TIMER_AUX_REGS_SVH
`define TIMER_AUX_REGS_SVH
// Control register a fields
`define CA_EDGE0 0
`define CA_SYNC 1
`define CA_ASTOP 2
`define CA_PIN0 3
// Control register b fields
`define CB_EDGE1 0
`define CB_PERIOD 1
`define CB_AUTO 2
`define CB_PIN1 3
// Timer control fields
`define TC_SRC_LO 0
`define TC_SRC_HI 1
`define TC_RUN 2
`define TC_PWM 3
// Trigger control fields
`define TR_T1EN 0
`define TR_BOTH 1
`define TR_POL 2
`define TR_INEN 3
// Reset values
`define CTRL_RST 4'h0
// Count sources
`define SRC_0 2'h0
`define SRC_1 2'h1
`define SRC_2 2'h2
`define SRC_3 2'h3
// Watchdog limit in machine cycles
`define WDT_LIMIT 65534
`endif

/* File: core/timer_aux_pkg.sv */
// Purpose: Types for the dual timer auxiliary control block
// Assumes: Nothing
// Notes: Instruction codes and trigger states
package timer_aux_pkg;
    // Instruction codes presented on the command port
    typedef enum logic [3:0] {
        ins_nop = 4'h0,
        ins_write_a = 4'h1,
        ins_read_a = 4'h2,
        ins_write_b = 4'h3,
        ins_read_b = 4'h4,
        ins_write_t1 = 4'h5,
        ins_write_t2 = 4'h6,
        ins_write_trig = 4'h7,
        ins_reload_t1 = 4'h8,
        ins_reload_t2l = 4'h9,
        ins_reload_t2h = 4'ha,
        ins_wdt_restart = 4'hb
    } instr_type;
    // Trigger start states, Gray coded along idle-armed-run
    typedef enum logic [1:0] {
        trg_idle = 2'h0,
        trg_armed = 2'h1,
        trg_run = 2'h3
    } trig_state_type;
endpackage : timer_aux_pkg

/* File: core/pin_edge.sv */
// Purpose: Synchronise one pin and report its edges
// Assumes: Pin is asynchronous to clk
// Notes: First flop feeds only the second
`timescale 1ns/1ps
module pin_edge (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    // Two-flop synchroniser plus history flop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end
    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule : pin_edge

/* File: tb/pulse_src.sv */
// Purpose: External pulse source feeding the counter and trigger pins
// Assumes: Runs on the bench clock, changes just after the rising edge
// Notes: Line rests low while the source is off
`timescale 1ns/1ps
module pulse_src (
    input wire logic clk,
    input wire logic en,
    input wire logic [7:0] half,
    output logic pulse
);
    logic [7:0] cnt_r;
    initial pulse = 1'b0;
    initial cnt_r = 8'h00;
    // Square wave, half period of half clocks
    always begin
        @(posedge clk);
        #1;
        if (!en) begin
            cnt_r = 8'h00;
            pulse = 1'b0;
        end else if (cnt_r + 8'h01 >= half) begin
            cnt_r = 8'h00;
            pulse = ~pulse;
        end else begin
            cnt_r = cnt_r + 8'h01;
        end
    end
endmodule : pulse_src

/* File: tb/tb_timer_aux.sv */
// Purpose: Self-checking bench for the dual timer auxiliary block
// Assumes: Watchdog limit shortened to 20 machine cycles
// Notes: Shared port enables tied low, port data and prescaler tick driven by the bench
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_timer_aux;
    import timer_aux_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, osc_tick = 1'b0, machine_cycle = 1'b0, src_en = 1'b0;
    logic psc = 1'b0, pa_out = 1'b0, pb_out = 1'b0;
    instr_type instr = ins_nop;
    logic [7:0] instr_data = 8'h00, half = 8'h04, period_r, p1, p2;
    logic [3:0] acc_out_r;
    logic pulse, c0_out, c0_oe, c1_out, c1_oe, irq1, irq2, pv, wdt;
    int n_fail = 0, check_count = 0, cyc = 0, n_irq1 = 0, n_irq2 = 0, n_tog = 0, n_wdt = 0, i0, i1, t0;
    // ****************************************************************
    // Clock, partner and device
    // ****************************************************************
    always #2.5 clk = ~clk;
    pulse_src i_src (.clk(clk), .en(src_en), .half(half), .pulse(pulse));
    timer_aux #(.W(8), .WDT_LIMIT(20)) i_dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr(instr), .instr_data(instr_data), .acc_out_r(acc_out_r), .prescaler_out(psc),
        .osc_tick(osc_tick), .machine_cycle(machine_cycle), .trigger_pin(pulse),
        .counter_pin_zero_in(pulse), .counter_pin_zero_out_r(c0_out), .counter_pin_zero_oe_r(c0_oe),
        .counter_pin_one_in(pulse), .counter_pin_one_out_r(c1_out), .counter_pin_one_oe_r(c1_oe),
        .shared_port_bit_a_out(pa_out), .shared_port_bit_a_oe(1'b0), .shared_port_bit_b_out(pb_out),
        .shared_port_bit_b_oe(1'b0), .timer1_irq_r(irq1), .timer2_irq_r(irq2), .period_r(period_r),
        .period_valid_r(pv), .wdt_reset_r(wdt));
    // Event counters and hang guard
    always @(posedge clk) begin
        cyc++;
        n_irq1 += (irq1 === 1'b1);
        n_irq2 += (irq2 === 1'b1);
        n_wdt += (wdt === 1'b1);
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    always @(c0_out) n_tog++;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic ins(input instr_type c, input logic [7:0] d);
        @(posedge clk);
        #1 instr_valid = 1'b1;
        instr = c;
        instr_data = d;
        @(posedge clk);
        #1 instr_valid = 1'b0;
    endtask : ins
    task automatic wait_pv(output logic [7:0] v);
        int k;
        v = 8'h00;
        for (k = 0; k < 300 && pv !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK(pv, 1'b1)
        v = period_r;
        @(posedge clk);
        #1;
    endtask : wait_pv
    // Cycles of one high and one low phase of counter pin 1
    task automatic measure(output int hi, output int lo);
        int k;
        hi = 0;
        lo = 0;
        for (k = 0; k < 100 && c1_out !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        for (k = 0; k < 100 && c1_out !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        while (c1_out === 1'b1 && hi < 100) begin
            hi++;
            @(posedge clk);
            #1;
        end
        while (c1_out === 1'b0 && lo < 100) begin
            lo++;
            @(posedge clk);
            #1;
        end
    endtask : measure
    // High samples of counter pin 1 over sixteen cycles
    task automatic count_hi(output int hi);
        hi = 0;
        repeat (16) begin
            @(posedge clk);
            #1;
            hi += (c1_out === 1'b1);
        end
    endtask : count_hi
    task automatic test_trig();
        osc_tick = 1'b1;
        ins(ins_write_trig, 8'h0d);
        ins(ins_write_a, 8'h06);
        ins(ins_reload_t1, 8'h02);
        ins(ins_write_t1, 8'h07);
        i0 = n_irq1;
        repeat (12) @(posedge clk);
        `CHK(n_irq1 - i0, 0)
        half = 8'h14;
        src_en = 1'b1;
        repeat (45) @(posedge clk);
        #1 src_en = 1'b0;
        repeat (10) @(posedge clk);
        `CHK(n_irq1 - i0, 1)
        ins(ins_write_t1, 8'h00);
        ins(ins_write_trig, 8'h00);
        ins(ins_write_a, 8'h00);
        osc_tick = 1'b0;
        $display("test_trig done");
    endtask : test_trig
    task automatic test_pwm();
        int hi;
        int lo;
        ins(ins_write_b, 8'h08);
        ins(ins_reload_t2l, 8'h02);
        ins(ins_reload_t2h, 8'h04);
        ins(ins_write_t2, 8'h0f);
        measure(hi, lo);
        `CHK(hi, 5)
        `CHK(lo, 3)
        ins(ins_reload_t1, 8'h00);
        ins(ins_write_t1, 8'h05);
        ins(ins_write_b, 8'h0c);
        count_hi(hi);
        `CHK(hi, 0)
        psc = 1'b1;
        @(posedge clk);
        #1 psc = 1'b0;
        count_hi(hi);
        `CHK(hi, 10)
        psc = 1'b1;
        @(posedge clk);
        #1 psc = 1'b0;
        count_hi(hi);
        `CHK(hi, 0)
        ins(ins_write_t2, 8'h00);
        ins(ins_write_t1, 8'h00);
        ins(ins_write_b, 8'h00);
        pa_out = 1'b1;
        pb_out = 1'b1;
        repeat (2) @(posedge clk);
        `CHK({c0_out, c1_out, c1_oe}, 3'b110)
        #1 pa_out = 1'b0;
        pb_out = 1'b0;
        $display("test_pwm done");
    endtask : test_pwm
    task automatic test_regs();
        ins(ins_read_a, 8'h00);
        `CHK(acc_out_r, 4'h0)
        ins(ins_read_b, 8'h00);
        `CHK(acc_out_r, 4'h0)
        ins(ins_write_a, 8'h05);
        ins(ins_write_b, 8'h0a);
        ins(ins_read_a, 8'h00);
        `CHK(acc_out_r, 4'h5)
        ins(ins_read_b, 8'h00);
        `CHK(acc_out_r, 4'ha)
        ins(ins_write_a, 8'h00);
        ins(ins_write_b, 8'h00);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_buzzer();
        osc_tick = 1'b1;
        ins(ins_write_a, 8'h08);
        ins(ins_reload_t1, 8'h03);
        i0 = n_irq1;
        t0 = n_tog;
        ins(ins_write_t1, 8'h07);
        repeat (60) @(posedge clk);
        ins(ins_write_t1, 8'h00);
        repeat (4) @(posedge clk);
        `CHK(c0_oe, 1'b1)
        `CHK(n_tog - t0, n_irq1 - i0)
        `CHK((n_irq1 - i0) >= 13, 1'b1)
        ins(ins_write_a, 8'h00);
        osc_tick = 1'b0;
        $display("test_buzzer done");
    endtask : test_buzzer
    task automatic test_events();
        ins(ins_write_a, 8'h01);
        ins(ins_reload_t2l, 8'h03);
        ins(ins_write_t2, 8'h06);
        i1 = n_irq2;
        half = 8'h04;
        src_en = 1'b1;
        repeat (64) @(posedge clk);
        #1 src_en = 1'b0;
        repeat (10) @(posedge clk);
        `CHK(n_irq2 - i1, 2)
        ins(ins_write_t2, 8'h00);
        $display("test_events done");
    endtask : test_events
    task automatic test_period();
        ins(ins_write_b, 8'h02);
        ins(ins_write_trig, 8'h0c);
        ins(ins_reload_t2l, 8'hff);
        ins(ins_write_t2, 8'h07);
        half = 8'h14;
        src_en = 1'b1;
        wait_pv(p1);
        wait_pv(p1);
        wait_pv(p2);
        `CHK(p1, p2)
        `CHK((8'hff - p2) >= 8'd38 && (8'hff - p2) <= 8'd41, 1'b1)
        #1 src_en = 1'b0;
        ins(ins_write_t2, 8'h00);
        ins(ins_write_b, 8'h00);
        $display("test_period done");
    endtask : test_period
    task automatic test_wdt();
        machine_cycle = 1'b1;
        i0 = n_wdt;
        repeat (6) begin
            ins(ins_wdt_restart, 8'h00);
            repeat (8) @(posedge clk);
        end
        repeat (11) @(posedge clk);
        `CHK(n_wdt - i0, 0)
        repeat (4) @(posedge clk);
        `CHK(n_wdt - i0, 1)
        $display("test_wdt done");
    endtask : test_wdt
    task automatic test_done();
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        test_regs();
        test_buzzer();
        test_events();
        test_period();
        test_trig();
        test_pwm();
        test_wdt();
        test_done();
    end
endmodule : tb_timer_aux
